// >>> core/reset_source_sequencer.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// RQ1 - six reset causes are told apart and reported on a cause code.
// RQ2 - the unaffected-class clear strobe fires only on power-on.
// RQ3 - the resettable-class strobe fires on power-on, pin, watchdog and brownout resets.
// RQ4 - a watchdog wake-up from sleep resumes operation without any register reset.
// RQ5 - timeout and powerdown flags take a pattern that identifies the cause.
// RQ6 - the external reset pin is filtered so that short pulses are ignored.
// RQ7 - a two-bit mode select picks one of four brownout modes.
// RQ8 - in mode 01 the soft brownout enable switches detection.
// RQ9 - in the hardware mode detection is off in sleep, on when awake, soft bit ignored.
// RQ10 - a brownout level lasting the minimum duration forces reset.
// RQ11 - reset holds until supply is good, then for the startup delay if enabled.
// RQ12 - the startup timer runs only when the startup delay enable is set.
// RQ13 - a brownout during the startup delay returns to brownout and restarts a full delay.
// RQ14 - any reset forces port pins to input and clears the compare/PWM state.
// RQ15 - the internal reset deasserts on a clock edge of this block.
module reset_source_sequencer #(
  parameter int STARTUP_CYCLES = reset_seq_pkg::STARTUP_CYCLES, // startup delay length
  parameter int BOR_CYCLES     = reset_seq_pkg::BOR_MIN_CYCLES, // brownout min duration
  parameter int PIN_CYCLES     = reset_seq_pkg::PIN_FILTER_CYCLES // pin filter length
) (
  input  wire logic       mclk,                 // 200 MHz clock
  input  wire logic       rst,                  // power-on reset, sync, high
  input  wire logic       external_reset_pin_n, // external reset pin, low active
  input  wire logic       supply_low,           // supply below brownout threshold
  input  wire logic       watchdog_timeout,     // watchdog expiry pulse
  input  wire logic       sleeping,             // core is in sleep
  input  wire logic [1:0] brownout_mode_select, // brownout mode field
  input  wire logic       soft_brownout_enable, // software brownout enable
  input  wire logic       startup_delay_enable, // startup delay enable
  output logic            chip_reset,           // internal reset, high active
  output logic            clear_unaffected,     // pulse: reset unaffected class
  output logic            clear_resettable,     // pulse: reset resettable class
  output logic            wake_pulse,           // pulse: watchdog wake from sleep
  output logic [2:0]      reset_cause,          // last cause code
  output logic            timeout_flag,         // timeout flag, low after wdt
  output logic            powerdown_flag,       // powerdown flag, low after sleep
  output logic            brownout_active,      // brownout detection enabled
  output logic [7:0]      port_dir,             // port direction, 1 = input
  output logic            ccp_clear             // compare/PWM state reset
);
  typedef enum logic [2:0] {
    st_reset = 3'b001,
    st_delay = 3'b010,
    st_run   = 3'b100
  } state_e;
  localparam int DW = $clog2(STARTUP_CYCLES + 1);
  localparam int BW = $clog2(BOR_CYCLES + 1);

  ////////////////////////////////////////////////////////////////////////////
  logic         pin_ok;
  state_e       state_reg, state_next;
  logic [DW-1:0] dly_reg, dly_next;
  logic [BW-1:0] bor_reg, bor_next;
  logic         chip_reset_reg, chip_reset_next;
  logic         clr_u_reg, clr_u_next;
  logic         clr_r_reg, clr_r_next;
  logic         wake_reg, wake_next;
  reset_seq_pkg::cause_e cause_reg, cause_next;
  logic         to_reg, to_next;
  logic         pd_reg, pd_next;
  logic         bor_en_reg, bor_en_next;
  logic [7:0]   dir_reg, dir_next;
  logic         ccp_reg, ccp_next;
  logic         bor_en;
  logic         bor_trip;
  logic         event_hit;

  // external pin filter
  pulse_filter #(
    .COUNT (PIN_CYCLES)
  ) u_pin_filter (
    .mclk      (mclk),
    .rst       (rst),
    .din       (!external_reset_pin_n),
    .qualified (pin_ok)                   // RQ6
  );

  ////////////////////////////////////////////////////////////////////////////
  // brownout enable by mode
  always_comb begin
    case (brownout_mode_select)           // RQ7
      reset_seq_pkg::BOR_MODE_OFF:  bor_en = 1'b0;
      reset_seq_pkg::BOR_MODE_SOFT: bor_en = soft_brownout_enable; // RQ8
      reset_seq_pkg::BOR_MODE_HW:   bor_en = !sleeping;            // RQ9
      reset_seq_pkg::BOR_MODE_ON:   bor_en = 1'b1;
      default:                      bor_en = 1'b1;
    endcase
  end

  // brownout duration counter
  always_comb begin
    bor_next = '0;
    bor_trip = 1'b0;
    if (bor_en && supply_low) begin
      if (bor_reg >= BW'(BOR_CYCLES - 1)) begin
        bor_trip = 1'b1;                  // RQ10
        bor_next = bor_reg;
      end else begin
        bor_next = bor_reg + BW'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset sequencing
  always_comb begin
    state_next      = state_reg;
    dly_next        = dly_reg;
    chip_reset_next = chip_reset_reg;
    clr_u_next      = 1'b0;
    clr_r_next      = 1'b0;
    wake_next       = 1'b0;
    cause_next      = cause_reg;
    to_next         = to_reg;
    pd_next         = pd_reg;
    dir_next        = dir_reg;
    ccp_next        = ccp_reg;
    event_hit       = 1'b0;
    // cause detection, brownout has priority over pin, pin over watchdog
    if (bor_trip) begin
      event_hit  = 1'b1;
      cause_next = reset_seq_pkg::cause_brownout; // RQ1
      to_next    = 1'b1;                          // RQ5
      pd_next    = 1'b1;
    end else if (pin_ok) begin
      event_hit  = 1'b1;
      cause_next = sleeping ? reset_seq_pkg::cause_pin_slp : reset_seq_pkg::cause_pin_run;
      pd_next    = sleeping ? 1'b0 : pd_reg;      // RQ5
    end else if (watchdog_timeout && state_reg == st_run) begin
      if (sleeping) begin
        wake_next  = 1'b1;                        // RQ4
        cause_next = reset_seq_pkg::cause_wdt_wake;
        to_next    = 1'b0;
        pd_next    = 1'b0;
      end else begin
        event_hit  = 1'b1;
        cause_next = reset_seq_pkg::cause_wdt_run;
        to_next    = 1'b0;                        // RQ5
        pd_next    = 1'b1;
      end
    end
    if (event_hit) begin
      clr_r_next      = 1'b1;                     // RQ3
      chip_reset_next = 1'b1;
      dir_next        = reset_seq_pkg::PORT_DIR_RESET; // RQ14
      ccp_next        = 1'b1;
      state_next      = st_reset;
      dly_next        = '0;
    end
    case (state_reg)
      st_reset: begin
        if (!event_hit && !(supply_low && bor_en) && !pin_ok) begin // RQ11
          if (startup_delay_enable) begin         // RQ12
            state_next = st_delay;
            dly_next   = '0;
          end else begin
            state_next      = st_run;
            chip_reset_next = 1'b0;               // RQ15
            ccp_next        = 1'b0;
          end
        end
      end
      st_delay: begin
        if (!event_hit) begin
          if (dly_reg >= DW'(STARTUP_CYCLES - 1)) begin
            state_next      = st_run;
            chip_reset_next = 1'b0;               // RQ15
            ccp_next        = 1'b0;
          end else begin
            dly_next = dly_reg + DW'(1);          // RQ11
          end
        end else begin
          dly_next = '0;                          // RQ13
        end
      end
      st_run: begin
      end
      default: begin
        state_next = st_reset;
      end
    endcase
  end

  // sequencing registers; power-on loads the full reset pattern
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg      <= st_reset;
      dly_reg        <= '0;
      bor_reg        <= '0;
      chip_reset_reg <= 1'b1;
      clr_u_reg      <= 1'b1;                     // RQ2
      clr_r_reg      <= 1'b1;
      wake_reg       <= 1'b0;
      cause_reg      <= reset_seq_pkg::cause_power_on;
      to_reg         <= 1'b1;
      pd_reg         <= 1'b1;
      bor_en_reg     <= 1'b0;
      dir_reg        <= reset_seq_pkg::PORT_DIR_RESET;
      ccp_reg        <= 1'b1;
    end else begin
      state_reg      <= state_next;
      dly_reg        <= dly_next;
      bor_reg        <= bor_next;
      chip_reset_reg <= chip_reset_next;
      clr_u_reg      <= clr_u_next;
      clr_r_reg      <= clr_r_next;
      wake_reg       <= wake_next;
      cause_reg      <= cause_next;
      to_reg         <= to_next;
      pd_reg         <= pd_next;
      bor_en_reg     <= bor_en;
      dir_reg        <= dir_next;
      ccp_reg        <= ccp_next;
    end
  end

  // outputs straight from flip-flops
  assign chip_reset       = chip_reset_reg;
  assign clear_unaffected = clr_u_reg;
  assign clear_resettable = clr_r_reg;
  assign wake_pulse       = wake_reg;
  assign reset_cause      = cause_reg;
  assign timeout_flag     = to_reg;
  assign powerdown_flag   = pd_reg;
  assign brownout_active  = bor_en_reg;
  assign port_dir         = dir_reg;
  assign ccp_clear        = ccp_reg;
endmodule

// >>> core/reset_seq_pkg.sv
package reset_seq_pkg;
  // reset cause codes
  typedef enum logic [2:0] {
    cause_none     = 3'h0,
    cause_power_on = 3'h1,
    cause_wdt_run  = 3'h2,
    cause_wdt_slp  = 3'h3,
    cause_pin_run  = 3'h4,
    cause_pin_slp  = 3'h5,
    cause_brownout = 3'h6,
    cause_wdt_wake = 3'h7
  } cause_e;

  // brownout mode select codes
  localparam logic [1:0] BOR_MODE_OFF  = 2'h0;
  localparam logic [1:0] BOR_MODE_SOFT = 2'h1;
  localparam logic [1:0] BOR_MODE_HW   = 2'h2;
  localparam logic [1:0] BOR_MODE_ON   = 2'h3;

  // timing
  localparam int CLK_MHZ          = 200;
  localparam int STARTUP_DELAY_MS = 64;
  localparam int STARTUP_CYCLES   = STARTUP_DELAY_MS * 1000 * CLK_MHZ;
  localparam int BOR_MIN_NS       = 100;
  localparam int BOR_MIN_CYCLES   = (BOR_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int PIN_FILTER_NS    = 2000;
  localparam int PIN_FILTER_CYCLES = (PIN_FILTER_NS * CLK_MHZ + 999) / 1000;

  // port direction reset value: all inputs
  localparam logic [7:0] PORT_DIR_RESET = 8'hff;
endpackage

// >>> core/pulse_filter.sv
`timescale 1ns/10ps
// accepts a level only after it has stood for a full count of cycles
module pulse_filter #(
  parameter int COUNT = 4
) (
  input  wire logic mclk,    // clock
  input  wire logic rst,     // synchronous reset
  input  wire logic din,     // raw level
  output logic      qualified // level held for COUNT cycles
);
  localparam int W = $clog2(COUNT + 1);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic         q_reg;
  logic         q_next;

  // count while input stands high, restart on any drop
  always_comb begin
    cnt_next = cnt_reg;
    q_next   = 1'b0;
    if (!din) begin
      cnt_next = '0;
    end else if (cnt_reg >= W'(COUNT - 1)) begin
      q_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_reg <= '0;
      q_reg   <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      q_reg   <= q_next;
    end
  end

  assign qualified = q_reg;
endmodule

// >>> verif/reset_seq_properties.sv
`timescale 1ns/10ps
module reset_seq_checker #(
  parameter int STARTUP_CYCLES = 20,
  parameter int BOR_CYCLES     = 3,
  parameter int PIN_CYCLES     = 4
) (
  input wire logic       mclk,                 // clock
  input wire logic       rst,                  // power-on reset
  input wire logic       external_reset_pin_n, // pin
  input wire logic       supply_low,           // dip
  input wire logic       watchdog_timeout,     // watchdog
  input wire logic       sleeping,             // sleep
  input wire logic [1:0] brownout_mode_select, // mode
  input wire logic       soft_brownout_enable, // soft enable
  input wire logic       startup_delay_enable, // delay enable
  input wire logic       chip_reset,           // reset out
  input wire logic       clear_unaffected,     // strobe
  input wire logic       clear_resettable,     // strobe
  input wire logic       wake_pulse,           // wake
  input wire logic [2:0] reset_cause,          // cause
  input wire logic       timeout_flag,         // flag
  input wire logic       powerdown_flag,       // flag
  input wire logic       brownout_active,      // detection on
  input wire logic [7:0] port_dir,             // directions
  input wire logic       ccp_clear             // pwm clear
);
  logic [15:0] pin_lo_reg, pin_lo_next, ok_reg, ok_next, bor_lo_reg, bor_lo_next;
  logic        bor_exp;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  // run lengths of pin low, supply good and active dip; expected detection enable
  always_comb begin
    pin_lo_next = external_reset_pin_n ? 16'h0000 : pin_lo_reg + 16'h0001;
    ok_next     = (rst || supply_low) ? 16'h0000 : ok_reg + 16'h0001;
    bor_lo_next = (!rst && supply_low && brownout_active) ? bor_lo_reg + 16'h0001 : 16'h0000;
    bor_exp     = brownout_mode_select == 2'h3 ||
                  (brownout_mode_select == 2'h1 && soft_brownout_enable) ||
                  (brownout_mode_select == 2'h2 && !sleeping);
  end
  // register the run lengths
  always_ff @(posedge mclk) begin
    pin_lo_reg <= pin_lo_next;
    ok_reg     <= ok_next;
    bor_lo_reg <= bor_lo_next;
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_por_state: assert property ($fell(rst) |-> chip_reset && clear_unaffected &&
    reset_cause == reset_seq_pkg::cause_power_on && timeout_flag && powerdown_flag)
    else $error("power-on state wrong");
  a_wdt_run: assert property (!sleeping && watchdog_timeout && !chip_reset &&
    !supply_low && external_reset_pin_n |-> ##[1:2] chip_reset && clear_resettable &&
    !clear_unaffected && reset_cause == reset_seq_pkg::cause_wdt_run && !timeout_flag &&
    powerdown_flag) else $error("watchdog reset wrong");
  a_wdt_wake: assert property (sleeping && watchdog_timeout && !chip_reset &&
    !supply_low && external_reset_pin_n |-> ##[1:2] wake_pulse && !chip_reset &&
    !clear_resettable) else $error("watchdog wake wrong");
  a_reset_ports: assert property (chip_reset |->
    port_dir == reset_seq_pkg::PORT_DIR_RESET && ccp_clear) else $error("ports not reset");
  a_delay_len: assert property ($fell(chip_reset) && $past(startup_delay_enable) &&
    $past(brownout_active) |-> ok_reg >= STARTUP_CYCLES) else $error("delay too short");
  a_bor_mode: assert property (!$past(rst) |-> brownout_active == $past(bor_exp))
    else $error("detection enable wrong");
  a_pin_filter: assert property ($rose(chip_reset) && (reset_cause ==
    reset_seq_pkg::cause_pin_run || reset_cause == reset_seq_pkg::cause_pin_slp) |->
    pin_lo_reg >= PIN_CYCLES) else $error("short pin pulse accepted");
  a_bor_long: assert property (bor_lo_reg == BOR_CYCLES + 2 |-> chip_reset)
    else $error("long dip ignored");
  c_brownout: cover property (chip_reset && reset_cause == reset_seq_pkg::cause_brownout);
  c_wake: cover property (wake_pulse);
  c_release: cover property ($fell(chip_reset));
endmodule

bind reset_source_sequencer reset_seq_checker #(.STARTUP_CYCLES(STARTUP_CYCLES),
  .BOR_CYCLES(BOR_CYCLES), .PIN_CYCLES(PIN_CYCLES)) reset_seq_checker_inst (.*);

// >>> verif/reset_partner_model.sv
`timescale 1ns/10ps
module reset_partner_model (
  input  wire logic pin_req,              // hold the pin low
  input  wire logic dip_req,              // pull supply under threshold
  output logic      external_reset_pin_n, // pin with pull-up
  output logic      supply_low            // comparator output
);
  // released pin floats to its pull-up level
  assign external_reset_pin_n = ~pin_req;
  assign supply_low           = dip_req;
endmodule

// >>> verif/testbench.sv
`timescale 1ns/10ps
module testbench;
  localparam int SC = 20;
  localparam int BC = 3;
  localparam int PC = 4;
  logic mclk = 1'b0, rst = 1'b1, watchdog_timeout = 1'b0, sleeping = 1'b0, pin_req = 1'b0;
  logic soft_brownout_enable = 1'b0, startup_delay_enable = 1'b1, dip_req = 1'b0;
  logic [1:0] brownout_mode_select = 2'h3;
  logic external_reset_pin_n, supply_low, chip_reset, clear_unaffected, clear_resettable;
  logic wake_pulse, timeout_flag, powerdown_flag, brownout_active, ccp_clear;
  logic [2:0] reset_cause;
  logic [7:0] port_dir;
  int err_count = 0, compares = 0, cyc = 0, n;
  reset_source_sequencer #(.STARTUP_CYCLES(SC), .BOR_CYCLES(BC), .PIN_CYCLES(PC))
    reset_source_sequencer_inst (.*);
  reset_partner_model reset_partner_model_inst (.*);
  ////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial forever #2.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      final_report();
    end
  end
  // compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge mclk);
  endtask
  // wait for chip reset to reach v, counting cycles
  task automatic wait_rst(input logic v, input int lim);
    n = 0;
    while (chip_reset !== v && n < lim) begin
      @(negedge mclk);
      n++;
    end
    check({7'h00, chip_reset}, {7'h00, v});
  endtask
  task automatic final_report;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(10);
    // reset values stand while rst is held; the clear strobe drops at the first edge after it
    check({4'h0, clear_unaffected, chip_reset, timeout_flag, powerdown_flag}, 8'h0f);
    check({5'h00, reset_cause}, 8'h01);
    check(port_dir, 8'hff);
    check({7'h00, ccp_clear}, 8'h01);
    rst <= 1'b0;
    wait_rst(1'b0, SC + 10);
    check({7'h00, n >= SC - 1 && n <= SC + 3}, 8'h01);
    check({7'h00, ccp_clear}, 8'h00);
    $display("test power-on done");
    watchdog_timeout <= 1'b1;
    tick(1);
    watchdog_timeout <= 1'b0;
    wait_rst(1'b1, 4);
    check({4'h0, clear_resettable, clear_unaffected, timeout_flag, powerdown_flag}, 8'h09);
    check({5'h00, reset_cause}, 8'h02);
    tick(8);
    dip_req <= 1'b1;
    tick(BC + 3);
    check({3'h0, timeout_flag, powerdown_flag, reset_cause}, 8'h1e);
    dip_req <= 1'b0;
    wait_rst(1'b0, SC + 10);
    check({7'h00, n >= SC - 1}, 8'h01);
    $display("test watchdog and brownout done");
    pin_req <= 1'b1;
    tick(PC - 2);
    pin_req <= 1'b0;
    tick(PC + 4);
    check({7'h00, chip_reset}, 8'h00);
    pin_req <= 1'b1;
    wait_rst(1'b1, PC + 6);
    check({3'h0, timeout_flag, powerdown_flag, reset_cause}, 8'h1c);
    pin_req <= 1'b0;
    wait_rst(1'b0, SC + 10);
    sleeping <= 1'b1;
    pin_req <= 1'b1;
    wait_rst(1'b1, PC + 6);
    check({3'h0, timeout_flag, powerdown_flag, reset_cause}, 8'h15);
    pin_req <= 1'b0;
    wait_rst(1'b0, SC + 10);
    tick(2);
    watchdog_timeout <= 1'b1;
    tick(1);
    watchdog_timeout <= 1'b0;
    n = 0;
    while (wake_pulse !== 1'b1 && n < 4) begin
      tick(1);
      n++;
    end
    check({5'h00, chip_reset, clear_resettable, wake_pulse}, 8'h01);
    check({3'h0, timeout_flag, powerdown_flag, reset_cause}, 8'h07);
    $display("test pin and wake done");
    for (int i = 0; i < 16; i++) begin
      brownout_mode_select <= i[1:0];
      soft_brownout_enable <= i[2];
      sleeping <= i[3];
      tick(2);
      check({7'h00, brownout_active}, {7'h00, i[1:0] == 2'h3 || (i[1:0] == 2'h1 && i[2]) ||
        (i[1:0] == 2'h2 && !i[3])});
    end
    brownout_mode_select <= 2'h2;
    dip_req <= 1'b1;
    tick(BC + 4);
    check({7'h00, chip_reset}, 8'h00);
    sleeping <= 1'b0;
    brownout_mode_select <= 2'h3;
    startup_delay_enable <= 1'b0;
    wait_rst(1'b1, BC + 4);
    dip_req <= 1'b0;
    wait_rst(1'b0, 4);
    $display("test modes done");
    final_report();
  end
endmodule
